// file: rtl/clock_startup_pkg.sv
// Constants, field layouts and types for the clock start-up timer
package clock_startup_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CLK_SELECT = 8'h00;
  localparam logic [7:0] ADDR_RC_TRIM    = 8'h04;
  localparam logic [7:0] ADDR_CTRL       = 8'h08;
  localparam logic [7:0] ADDR_STATUS     = 8'h0C;

  // Selection and control register layout
  localparam int SEL_LSB   = 0;
  localparam int SEL_W     = 4;
  localparam int SUT_LSB   = 4;
  localparam int SUT_W     = 2;
  localparam int COUT_BIT  = 6;
  localparam int CMD_SWITCH_BIT = 0;

  // Status register layout
  localparam int ST_STATE_LSB = 0;
  localparam int ST_CORE_BIT  = 3;
  localparam int ST_RSVD_BIT  = 4;
  localparam int ST_XMODE_LSB = 5;

  // Source codes
  localparam int                 XTAL_BIT    = 3;
  localparam int                 XMODE_LSB   = 1;
  localparam logic [SEL_W-1:0]   SEL_LP_OSC  = 4'h3;
  localparam logic [SEL_W-1:0]   SEL_EXT_CLK = 4'h0;
  localparam logic [SUT_W-1:0]   SUT_NONE    = 2'h0;
  localparam logic [SUT_W-1:0]   SUT_SHORT   = 2'h1;
  localparam logic [SUT_W-1:0]   SUT_LONG    = 2'h2;

  // Start-up counts in source cycles and watchdog cycles
  localparam int CNT_W = 15;
  localparam int WDT_W = 14;
  localparam logic [CNT_W-1:0] CYC_SHORT    = 15'h0006;
  localparam logic [CNT_W-1:0] CYC_RESET    = 15'h000E;
  localparam logic [CNT_W-1:0] CYC_XTAL_MIN = 15'h0102;
  localparam logic [CNT_W-1:0] CYC_XTAL_MED = 15'h0400;
  localparam logic [WDT_W-1:0] WDT_SHORT    = 14'h0200;

  // Bus answers and the zero read value
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

  typedef enum logic [1:0] {
    WDT_NONE  = 2'h0,
    WDT_4MS   = 2'h1,
    WDT_64MS  = 2'h2
  } wdt_e;

  typedef enum logic [2:0] {
    PH_LOAD  = 3'h0,
    PH_WDT   = 3'h1,
    PH_SRC   = 3'h3,
    PH_RUN   = 3'h2,
    PH_SLEEP = 3'h6
  } phase_e;

  typedef struct packed {
    logic [CNT_W-1:0] cyc;
    wdt_e             wdt;
    logic             rsvd;
  } startup_s;

endpackage

// file: rtl/edge_cycle_counter.sv
// Synchronised edge counter that times a number of cycles of a foreign clock
`timescale 1ns/1ps
module edge_cycle_counter #(
  parameter int W = 15
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         async_in,
  input  wire logic         start,
  input  wire logic [W-1:0] target,
  output logic              done,
  output logic              busy
);

  localparam logic [W-1:0] ONE = W'(1);

  typedef struct packed {
    logic         sync1;
    logic         sync2;
    logic         prev;
    logic [W-1:0] cnt;
    logic         busy;
    logic         done;
  } ctr_s;

  ctr_s q;
  ctr_s n;

  always_comb begin
    n       = q;
    n.sync1 = async_in;
    n.sync2 = q.sync1;
    n.prev  = q.sync2;
    n.done  = 1'b0;
    if (start) begin
      n.cnt  = target;
      n.busy = (target != '0);
      n.done = (target == '0);
    end else if (q.busy && q.sync2 && !q.prev) begin
      n.cnt = q.cnt - ONE;
      if (q.cnt == ONE) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign done = q.done;
  assign busy = q.busy;

endmodule

// file: rtl/clock_source_startup_timer.sv
// Start-up timer and core clock gate control for the selectable clock sources
//
// How it works
// - Reset copies factory trim into RC trim register
// - Low-power oscillator selectable by fuses or field
// - Low-power osc: 6 cycles, reset adds 14/4ms/64ms
// - Crystal mode decoded from selection bits three-one
// - Crystal delay from bit zero plus start-up code
// - Bit zero low: 258 or 1024 cycles
// - Bit zero high: 1024 or 16384 cycles
// - Cycle counts on every wake, extras only reset
// - External clock: 6 cycles, reset adds 14/4ms/64ms
// - Reset latches fuse bits six-zero into selection register
// - Count selected source cycles before core runs
// - Watchdog counts 512 or 8192 for reset delay
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module clock_source_startup_timer
  import clock_startup_pkg::*;
#(
  parameter int unsigned XTAL_LONG_CYC = 16384,
  parameter int unsigned WDT_LONG_CYC  = 8192
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  fuse_low,
  input  wire logic [7:0]  sig_trim,
  input  wire logic        src_clk_in,
  input  wire logic        wdt_osc_in,
  input  wire logic        sleep_req,
  input  wire logic        wake_req,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             core_clk_en,
  output logic [3:0]       src_select,
  output logic             lp_osc_en,
  output logic             xtal_osc_en,
  output logic [2:0]       xtal_mode,
  output logic             ext_clk_en,
  output logic [7:0]       rc_trim_value,
  output logic             clk_out_en
);

  localparam logic [CNT_W-1:0] CYC_XTAL_LONG = CNT_W'(XTAL_LONG_CYC);
  localparam logic [WDT_W-1:0] WDT_LONG      = WDT_W'(WDT_LONG_CYC);
  typedef struct packed {
    phase_e           phase;
    logic [SEL_W-1:0] sel_fld;
    logic [SUT_W-1:0] sut_fld;
    logic             cout_fld;
    logic [7:0]       trim;
    logic [SEL_W-1:0] act_sel;
    logic [SUT_W-1:0] act_sut;
    logic             core_en;
    logic             lp_en;
    logic             xtal_en;
    logic [2:0]       xmode;
    logic             ext_en;
    logic             clkout_en;
    logic             src_start;
    logic [CNT_W-1:0] src_tgt;
    logic             wdt_start;
    logic [WDT_W-1:0] wdt_tgt;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             aw_got;
    logic [7:0]       aw_addr;
    logic             w_got;
    logic [7:0]       w_data;
    logic             w_strb0;
  } top_s;
  top_s q;
  top_s n;
  logic src_done, wdt_done;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up decode

  function automatic startup_s decode(input logic [SEL_W-1:0] sel, input logic [SUT_W-1:0] startup_code_fuses);
    startup_s d;
    d.cyc  = CYC_SHORT;
    d.wdt  = WDT_NONE;
    d.rsvd = 1'b0;
    if (sel[XTAL_BIT]) begin
      case ({sel[0], startup_code_fuses})
        3'h0, 3'h1:       d.cyc = CYC_XTAL_MIN;
        3'h2, 3'h3, 3'h4: d.cyc = CYC_XTAL_MED;
        default:          d.cyc = CYC_XTAL_LONG;
      endcase
      case ({sel[0], startup_code_fuses})
        3'h1, 3'h4, 3'h7: d.wdt = WDT_64MS;
        3'h0, 3'h3, 3'h6: d.wdt = WDT_4MS;
        default:          d.wdt = WDT_NONE;
      endcase
    end else begin
      case (startup_code_fuses)
        SUT_NONE:  d.wdt = WDT_NONE;
        SUT_SHORT: d.wdt = WDT_4MS;
        SUT_LONG:  d.wdt = WDT_64MS;
        default: begin
          d.wdt  = WDT_64MS;
          d.rsvd = 1'b1;
        end
      endcase
    end
    return d;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return (addr == ADDR_CLK_SELECT) || (addr == ADDR_RC_TRIM) ||
           (addr == ADDR_CTRL) || (addr == ADDR_STATUS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    startup_s         dec;
    logic             wr_go;
    logic             sw_go;
    logic [SEL_W-1:0] nsel;
    dec       = decode(q.act_sel, q.act_sut);
    wr_go     = 1'b0;
    sw_go     = 1'b0;
    nsel      = q.act_sel;
    n         = q;
    n.src_start = 1'b0;
    n.wdt_start = 1'b0;

    // Write channel
    if (q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (awvalid && q.awready) begin
      n.aw_got  = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      n.w_got   = 1'b1;
      n.w_data  = wdata[7:0];
      n.w_strb0 = wstrb[0];
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      wr_go    = 1'b1;
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = mapped(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr_go && q.w_strb0) begin
      case (q.aw_addr)
        ADDR_CLK_SELECT: begin
          n.sel_fld  = q.w_data[SEL_LSB +: SEL_W];
          n.sut_fld  = q.w_data[SUT_LSB +: SUT_W];
          n.cout_fld = q.w_data[COUT_BIT];
        end
        ADDR_RC_TRIM: n.trim = q.w_data;
        ADDR_CTRL:    sw_go = q.w_data[CMD_SWITCH_BIT];
        default:      n.trim = q.trim;
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;

    // Read channel
    if (q.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      n.rdata  = RD_ZERO;
      case (araddr)
        ADDR_CLK_SELECT: begin
          n.rdata[SEL_LSB +: SEL_W] = q.sel_fld;
          n.rdata[SUT_LSB +: SUT_W] = q.sut_fld;
          n.rdata[COUT_BIT]         = q.cout_fld;
        end
        ADDR_RC_TRIM: n.rdata[7:0] = q.trim;
        ADDR_STATUS: begin
          n.rdata[ST_STATE_LSB +: 3] = q.phase;
          n.rdata[ST_CORE_BIT]       = q.core_en;
          n.rdata[ST_RSVD_BIT]       = dec.rsvd;
          n.rdata[ST_XMODE_LSB +: 3] = q.xmode;
        end
        default: n.rdata = RD_ZERO;
      endcase
    end
    n.arready = !n.rvalid;

    // Start-up sequence
    case (q.phase)
      PH_LOAD: begin
        n.trim     = sig_trim;
        n.sel_fld  = fuse_low[SEL_LSB +: SEL_W];
        n.sut_fld  = fuse_low[SUT_LSB +: SUT_W];
        n.cout_fld = fuse_low[COUT_BIT];
        n.act_sel  = fuse_low[SEL_LSB +: SEL_W];
        n.act_sut  = fuse_low[SUT_LSB +: SUT_W];
        nsel       = fuse_low[SEL_LSB +: SEL_W];
        dec        = decode(n.act_sel, n.act_sut);
        n.src_tgt  = dec.cyc + CYC_RESET;
        n.wdt_tgt  = (dec.wdt == WDT_64MS) ? WDT_LONG : WDT_SHORT;
        if (dec.wdt == WDT_NONE) begin
          n.src_start = 1'b1;
          n.phase     = PH_SRC;
        end else begin
          n.wdt_start = 1'b1;
          n.phase     = PH_WDT;
        end
      end
      PH_WDT: begin
        if (wdt_done) begin
          n.src_start = 1'b1;
          n.phase     = PH_SRC;
        end
      end
      PH_SRC: begin
        if (src_done) begin
          n.core_en = 1'b1;
          n.phase   = PH_RUN;
        end
      end
      PH_RUN: begin
        if (sleep_req) begin
          n.core_en = 1'b0;
          n.phase   = PH_SLEEP;
        end else if (sw_go) begin
          n.core_en   = 1'b0;
          n.act_sel   = n.sel_fld;
          n.act_sut   = n.sut_fld;
          nsel        = n.sel_fld;
          dec         = decode(n.sel_fld, n.sut_fld);
          n.src_tgt   = dec.cyc;
          n.src_start = 1'b1;
          n.phase     = PH_SRC;
        end
      end
      PH_SLEEP: begin
        if (wake_req) begin
          n.src_tgt   = dec.cyc;
          n.src_start = 1'b1;
          n.phase     = PH_SRC;
        end
      end
      default: n.phase = PH_LOAD;
    endcase

    // Oscillator enables follow the active selection
    n.lp_en     = (nsel == SEL_LP_OSC) && (n.phase != PH_SLEEP);
    n.ext_en    = (nsel == SEL_EXT_CLK) && (n.phase != PH_SLEEP);
    n.xtal_en   = nsel[XTAL_BIT] && (n.phase != PH_SLEEP);
    n.xmode     = nsel[XMODE_LSB +: 3];
    n.clkout_en = n.cout_fld && n.core_en;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0;
      q.phase   <= PH_LOAD;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source and watchdog cycle counters

  edge_cycle_counter #(
    .W (CNT_W)
  ) u_src_count (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (src_clk_in),
    .start    (q.src_start),
    .target   (q.src_tgt),
    .done     (src_done),
    .busy     ()
  );

  edge_cycle_counter #(
    .W (WDT_W)
  ) u_wdt_count (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (wdt_osc_in),
    .start    (q.wdt_start),
    .target   (q.wdt_tgt),
    .done     (wdt_done),
    .busy     ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign awready       = q.awready;
  assign wready        = q.wready;
  assign bvalid        = q.bvalid;
  assign bresp         = q.bresp;
  assign arready       = q.arready;
  assign rvalid        = q.rvalid;
  assign rdata         = q.rdata;
  assign rresp         = q.rresp;
  assign core_clk_en   = q.core_en;
  assign src_select    = q.act_sel;
  assign lp_osc_en     = q.lp_en;
  assign xtal_osc_en   = q.xtal_en;
  assign xtal_mode     = q.xmode;
  assign ext_clk_en    = q.ext_en;
  assign rc_trim_value = q.trim;
  assign clk_out_en    = q.clkout_en;

endmodule

// file: dv/osc_model.sv
// Far-side oscillators: selected clock source and watchdog
`timescale 1ns/1ps
module osc_model #(
  parameter int HALF_NS = 50,
  parameter int WDT_HALF_NS = 62
) (
  input  wire logic en,
  output logic      src_clk,
  output logic      wdt_clk
);
  initial begin
    src_clk = 1'b0;
    wdt_clk = 1'b0;
  end
  // Resonator-like source, runs only while enabled, rests low
  always #(HALF_NS) src_clk = en ? ~src_clk : 1'b0;
  // Watchdog oscillator runs free
  always #(WDT_HALF_NS) wdt_clk = ~wdt_clk;
endmodule

// file: dv/clock_startup_chk.sv
// Port-level checks for the clock start-up timer
`timescale 1ns/1ps
module clock_startup_chk
  import clock_startup_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] sig_trim,
  input wire logic       sleep_req,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       core_clk_en,
  input wire logic [3:0] src_select,
  input wire logic       lp_osc_en,
  input wire logic       xtal_osc_en,
  input wire logic [2:0] xtal_mode,
  input wire logic       ext_clk_en,
  input wire logic [7:0] rc_trim_value,
  input wire logic       clk_out_en
);
  logic [1:0] since_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Edges since reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) since_r <= 2'h0;
    else if (since_r != 2'h3) since_r <= since_r + 2'h1;
  end
  trim_load_a: assert property (since_r == 2'h1 |-> rc_trim_value == sig_trim) else $error("trim not loaded");
  sel_latch_a: assert property (since_r == 2'h1 |-> src_select == fuse_low[3:0])
    else $error("fuse not latched");
  lp_code_a: assert property (lp_osc_en |-> src_select == SEL_LP_OSC) else $error("lp enable bad");
  xtal_code_a: assert property (xtal_osc_en |-> src_select[3]) else $error("xtal enable bad");
  xmode_dec_a: assert property (xtal_mode == src_select[3:1]) else $error("xtal mode bad");
  ext_code_a: assert property (ext_clk_en |-> src_select == SEL_EXT_CLK) else $error("ext enable bad");
  cout_gate_a: assert property (clk_out_en |-> core_clk_en) else $error("clock out ungated");
  core_osc_a: assert property (core_clk_en |-> lp_osc_en || xtal_osc_en || ext_clk_en)
    else $error("core w/o osc");
  wake_min_a: assert property ($rose(core_clk_en) |-> !$past(core_clk_en, 8) && !$past(core_clk_en, 16))
    else $error("start too short");
  sleep_gate_a: assert property (sleep_req && core_clk_en |-> ##[1:2] !core_clk_en)
    else $error("sleep no gate");
  sleep_osc_a: assert property (sleep_req && core_clk_en |-> ##[1:2] !(lp_osc_en || xtal_osc_en || ext_clk_en))
    else $error("sleep osc on");
  read_ans_a: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
  write_ans_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("no write answer");
  ar_block_a: assert property (rvalid |-> !arready) else $error("read not refused");
endmodule

bind clock_source_startup_timer clock_startup_chk u_chk (.mclk, .rst_n, .fuse_low, .sig_trim, .sleep_req,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .core_clk_en, .src_select,
  .lp_osc_en, .xtal_osc_en, .xtal_mode, .ext_clk_en, .rc_trim_value, .clk_out_en);

// file: dv/tb_top.sv
// Self-checking bench for the clock start-up timer
`timescale 1ns/1ps
module tb_top;
  import clock_startup_pkg::*;
  localparam int SP = 100;
  localparam int WP = 124;
  logic        mclk, rst_n, sleep_req, wake_req, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  fuse_low, sig_trim, awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  wire logic   src_clk_in, wdt_osc_in, awready, wready, bvalid, arready, rvalid;
  wire logic   core_clk_en, lp_osc_en, xtal_osc_en, ext_clk_en, clk_out_en;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0]  src_select;
  wire logic [2:0]  xtal_mode;
  wire logic [7:0]  rc_trim_value;
  int          err_total, tests_run;

  clock_source_startup_timer #(.XTAL_LONG_CYC(40), .WDT_LONG_CYC(20)) dut (.mclk, .rst_n, .fuse_low, .sig_trim,
    .src_clk_in, .wdt_osc_in, .sleep_req, .wake_req, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .core_clk_en, .src_select, .lp_osc_en, .xtal_osc_en, .xtal_mode, .ext_clk_en, .rc_trim_value, .clk_out_en);
  osc_model osc (.en(lp_osc_en | xtal_osc_en | ext_clk_en), .src_clk(src_clk_in), .wdt_clk(wdt_osc_in));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_ns(input int got, input int e);
    tests_run++;
    if (got < e - 2 * SP - WP || got > e + 2 * SP + WP + 400) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, e);
    end
  endtask
  function automatic int exp_ns(input logic [7:0] f, input bit rst);
    int cyc, w, idx;
    idx = int'({f[0], f[5:4]});
    if (f[3]) begin
      cyc = idx < 2 ? 258 : idx < 5 ? 1024 : 40;
      w = idx % 3 == 0 ? 512 : idx % 3 == 1 ? 20 : 0;
    end else begin
      cyc = 6;
      w = f[5:4] == 2'h0 ? 0 : f[5:4] == 2'h1 ? 512 : 20;
    end
    return rst ? (cyc + 14) * SP + w * WP : cyc * SP;
  endfunction
  task automatic do_reset(input logic [7:0] f);
    @(posedge mclk);
    rst_n <= 1'b0;
    fuse_low <= f;
    sig_trim <= f ^ 8'hA5;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
  endtask
  task automatic wait_core(output int ns);
    realtime t0 = $realtime;
    forever begin
      @(posedge mclk);
      if (core_clk_en === 1'b1) break;
    end
    ns = int'($realtime - t0);
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_startup();
    logic [7:0] tbl [16] = '{8'h03, 8'h13, 8'h23, 8'h10, 8'h20, 8'h0C, 8'h1C, 8'h2C,
                             8'h3C, 8'h0D, 8'h1D, 8'h2D, 8'h3D, 8'h08, 8'h2A, 8'h7F};
    int ns;
    foreach (tbl[i]) begin
      do_reset(tbl[i]);
      wait_core(ns);
      chk_ns(ns, exp_ns(tbl[i], 1'b1));
      chk(rc_trim_value, tbl[i] ^ 8'hA5);
      chk(src_select, tbl[i][3:0]);
      chk(xtal_mode, tbl[i][3:1]);
      chk({lp_osc_en, xtal_osc_en, ext_clk_en, clk_out_en},
          {tbl[i][3:0] == 4'h3, tbl[i][3], tbl[i][3:0] == 4'h0, tbl[i][6]});
    end
  endtask
  task automatic t_sleep();
    int ns;
    do_reset(8'h3C);
    wait_core(ns);
    sleep_req <= 1'b1;
    @(posedge mclk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({core_clk_en, lp_osc_en, xtal_osc_en, ext_clk_en}, 4'h0);
    wake_req <= 1'b1;
    @(posedge mclk);
    wake_req <= 1'b0;
    wait_core(ns);
    chk_ns(ns, exp_ns(8'h3C, 1'b0));
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    int ns;
    do_reset(8'h33);
    wait_core(ns);
    chk_ns(ns, exp_ns(8'h23, 1'b1));
    axi_read(ADDR_STATUS, d, r);
    chk(d[4:0], 5'h1A);
    axi_read(ADDR_CLK_SELECT, d, r);
    chk(d, 32'h33);
    axi_write(ADDR_RC_TRIM, 32'h5A, r);
    axi_read(ADDR_RC_TRIM, d, r);
    chk(d, 32'h5A);
    chk(r, RESP_OKAY);
    axi_write(ADDR_CLK_SELECT, 32'h10, r);
    axi_write(ADDR_CTRL, 32'h1, r);
    chk(core_clk_en, 1'b0);
    wait_core(ns);
    chk_ns(ns, exp_ns(8'h10, 1'b0));
    chk({ext_clk_en, src_select}, 5'h10);
    axi_read(8'h10, d, r);
    chk(d, RD_ZERO);
    chk(r, RESP_SLVERR);
    axi_write(8'h10, 32'hFF, r);
    chk(r, RESP_SLVERR);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #2ms;
    err_total++;
    finish_test();
  end
  initial begin
    {rst_n, sleep_req, wake_req, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {fuse_low, sig_trim, awaddr, araddr} = 32'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    err_total = 0;
    tests_run = 0;
    t_startup();
    t_sleep();
    t_regs();
    finish_test();
  end
endmodule
